/* hw/apcb_pin_sync.sv */
// three-flop synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ns
module apcb_pin_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] pin_async,
    output logic [3:0] pin_level
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] level;
    } apcb_sync_state_t;

    apcb_sync_state_t state;
    apcb_sync_state_t next_state;

    // ----------------------------------------------------------------
    // shift chain; s1 is looked at by s2 only
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.s1 = pin_async;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // a change counts only once two stages agree, so a glitch of one sample is dropped
        for (int i = 0; i < 4; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.level[i] = state.s3[i];
            end
        end
    end

    // registers, synchronous reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_level = state.level;

endmodule

/* hw/apcb_pkg.sv */
// package of constants and types for the auxiliary pin control bank
package apcb_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PINS_ONE_TWO = 8'h59;
    localparam logic [7:0] IDX_PINS_THREE_FOUR = 8'h5a;
    localparam logic [7:0] IDX_PIN_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h61;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h62;

    // ----------------------------------------------------------------
    // field positions inside one pin nibble
    // ----------------------------------------------------------------
    localparam int FLD_DIR = 0;
    localparam int FLD_POLARITY = 1;
    localparam int FLD_EDGE_MODE = 2;
    localparam int FLD_OUT_LEVEL = 3;
    localparam int PIN_COUNT = 4;

    // ----------------------------------------------------------------
    // values after power-on; the two pin values also on suspend entry
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PINS_ONE_TWO = 8'h00;
    localparam logic [7:0] RST_PINS_THREE_FOUR = 8'h90;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // one pin nibble, msb first
    typedef struct packed {
        logic out_level;
        logic edge_mode;
        logic polarity;
        logic dir;
    } apcb_pin_cfg_t;

    // ahb-lite request bundle, driven by the master
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } apcb_ahb_req_t;

    // ahb-lite answer bundle, driven by this slave
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } apcb_ahb_rsp_t;

endpackage

/* hw/apcb_top.sv */
// auxiliary pin control bank: four configurable pins behind an ahb-lite slave
//
// Functional notes
// - Register 0x59 low nibble configures pin one: direction, polarity, reporting, level.
// - Register 0x59 high nibble configures pin two with the same meanings.
// - Register 0x5A low nibble configures pin three.
// - Register 0x5A high nibble configures pin four.
// - Polarity 0 makes a low input true; polarity 1 makes high true.
// - Level mode: status bit is one exactly while the input is true.
// - Edge mode: status bit latches true events until the status register is read.
// - Output pin drives low for level bit 0, high for level bit 1.
// - Power-on and suspend entry put pins one to three back to input.
// - Power-on and suspend entry make pin four an output driving high.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module apcb_top (
    input wire logic clock,
    input wire logic rstn,
    input wire apcb_pkg::apcb_ahb_req_t ahb_req,
    output apcb_pkg::apcb_ahb_rsp_t ahb_rsp,
    input wire logic usb_suspend,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic irq
);

    // ----------------------------------------------------------------
    // state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        apcb_pkg::apcb_pin_cfg_t [3:0] cfg;
        logic [3:0] edge_latch;
        logic [3:0] prev_true;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic susp_prev;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_index;
        apcb_pkg::apcb_ahb_rsp_t rsp;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
        logic irq;
    } apcb_state_t;

    apcb_state_t state;
    apcb_state_t next_state;
    logic [3:0] pin_level;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // true condition of one input under its polarity
    function automatic logic pin_is_true(input apcb_pkg::apcb_pin_cfg_t c, input logic lvl);
        pin_is_true = c.polarity ? lvl : ~lvl;
    endfunction

    // status bit of one pin as software sees it
    function automatic logic pin_status(input apcb_pkg::apcb_pin_cfg_t c, input logic lvl,
                                        input logic latch);
        if (c.dir) begin
            pin_status = 1'h0;
        end else if (c.edge_mode) begin
            pin_status = latch;
        end else begin
            pin_status = pin_is_true(c, lvl);
        end
    endfunction

    // default configuration after power-on or suspend entry
    function automatic logic [15:0] default_cfg();
        default_cfg = {apcb_pkg::RST_PINS_THREE_FOUR, apcb_pkg::RST_PINS_ONE_TWO};
    endfunction

    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    apcb_pin_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .pin_async(pin_in),
        .pin_level(pin_level)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic addr_take;
        logic addr_hit;
        logic status_read;
        logic [3:0] now_true;
        logic [3:0] rise;
        logic [3:0] stat_view;
        logic [3:0] irq_clr;
        logic [7:0] wbyte;
        logic [31:0] rdata;
        apcb_state_t cur;

        addr_take = 1'h0;
        addr_hit = 1'h0;
        status_read = 1'h0;
        now_true = '0;
        rise = '0;
        stat_view = '0;
        irq_clr = '0;
        wbyte = ahb_req.hwdata[7:0];
        rdata = '0;
        cur = state;
        next_state = state;

        // data phase of a pending write lands first, so a read right behind it sees it
        if (state.dp_valid && state.dp_write) begin
            unique case (state.dp_index)
                apcb_pkg::IDX_PINS_ONE_TWO: begin
                    cur.cfg[0] = apcb_pkg::apcb_pin_cfg_t'(wbyte[3:0]);
                    cur.cfg[1] = apcb_pkg::apcb_pin_cfg_t'(wbyte[7:4]);
                end
                apcb_pkg::IDX_PINS_THREE_FOUR: begin
                    cur.cfg[2] = apcb_pkg::apcb_pin_cfg_t'(wbyte[3:0]);
                    cur.cfg[3] = apcb_pkg::apcb_pin_cfg_t'(wbyte[7:4]);
                end
                apcb_pkg::IDX_IRQ_MASK: begin
                    cur.irq_mask = wbyte[3:0];
                end
                apcb_pkg::IDX_IRQ_STATUS: begin
                    irq_clr = wbyte[3:0];
                end
                default: begin
                    // unmapped or read-only: write is dropped
                end
            endcase
        end

        // suspend entry overrides software, reloading the pin configuration as power-on does
        next_state.susp_prev = usb_suspend;
        if (usb_suspend && !state.susp_prev) begin
            cur.cfg = default_cfg();
        end
        next_state.cfg = cur.cfg;
        next_state.irq_mask = cur.irq_mask;

        // true conditions and false-to-true events of input pins
        for (int i = 0; i < apcb_pkg::PIN_COUNT; i++) begin
            now_true[i] = pin_is_true(state.cfg[i], pin_level[i]) & ~state.cfg[i].dir;
            rise[i] = now_true[i] & ~state.prev_true[i];
            stat_view[i] = pin_status(state.cfg[i], pin_level[i], state.edge_latch[i]);
        end
        next_state.prev_true = now_true;

        // address phase decode
        addr_take = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == apcb_pkg::HTRANS_NONSEQ);
        addr_hit = (ahb_req.haddr[31:10] == '0) && (ahb_req.haddr[1:0] == 2'h0);
        next_state.dp_valid = addr_take && addr_hit;
        next_state.dp_write = ahb_req.hwrite;
        next_state.dp_index = ahb_req.haddr[9:2];

        // read data is registered during the address phase, ready with zero wait
        if (addr_take && addr_hit && !ahb_req.hwrite) begin
            unique case (ahb_req.haddr[9:2])
                apcb_pkg::IDX_PINS_ONE_TWO: begin
                    rdata = {24'h000000, cur.cfg[1], cur.cfg[0]};
                end
                apcb_pkg::IDX_PINS_THREE_FOUR: begin
                    rdata = {24'h000000, cur.cfg[3], cur.cfg[2]};
                end
                apcb_pkg::IDX_PIN_STATUS: begin
                    rdata = {28'h0000000, stat_view};
                    status_read = 1'h1;
                end
                apcb_pkg::IDX_IRQ_STATUS: begin
                    rdata = {28'h0000000, state.irq_stat & ~irq_clr};
                end
                apcb_pkg::IDX_IRQ_MASK: begin
                    rdata = {28'h0000000, cur.irq_mask};
                end
                default: begin
                    rdata = '0;
                end
            endcase
        end
        next_state.rsp.hrdata = rdata;
        next_state.rsp.hreadyout = 1'h1;
        next_state.rsp.hresp = apcb_pkg::HRESP_OKAY;

        // edge latches: a true sample in the read cycle survives the clear
        for (int i = 0; i < apcb_pkg::PIN_COUNT; i++) begin
            if (status_read) begin
                next_state.edge_latch[i] = now_true[i] & state.cfg[i].edge_mode;
            end else if (now_true[i] && state.cfg[i].edge_mode) begin
                next_state.edge_latch[i] = 1'h1;
            end
            if (state.cfg[i].dir || !state.cfg[i].edge_mode) begin
                next_state.edge_latch[i] = 1'h0;
            end
        end

        // sticky interrupt status, write one to clear, set wins
        next_state.irq_stat = (state.irq_stat & ~irq_clr) | rise;
        next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

        // pin drivers registered from the next configuration, so they move on the same edge
        for (int i = 0; i < apcb_pkg::PIN_COUNT; i++) begin
            next_state.pin_oe_n[i] = ~cur.cfg[i].dir;
            next_state.pin_out[i] = cur.cfg[i].dir & cur.cfg[i].out_level;
        end
    end

    // ----------------------------------------------------------------
    // registers, synchronous reset
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state.cfg <= default_cfg();
            state.edge_latch <= '0;
            state.prev_true <= '1; // no false event while the synchroniser still shows its reset level
            state.irq_stat <= '0;
            state.irq_mask <= apcb_pkg::RST_IRQ_MASK;
            state.susp_prev <= 1'h0;
            state.dp_valid <= 1'h0;
            state.dp_write <= 1'h0;
            state.dp_index <= '0;
            state.rsp.hrdata <= '0;
            state.rsp.hreadyout <= 1'h1;
            state.rsp.hresp <= apcb_pkg::HRESP_OKAY;
            state.pin_out <= 4'h8;
            state.pin_oe_n <= 4'h7;
            state.irq <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs, straight from flip-flops
    // ----------------------------------------------------------------
    assign ahb_rsp = state.rsp;
    assign pin_out = state.pin_out;
    assign pin_oe_n = state.pin_oe_n;
    assign irq = state.irq;

endmodule

/* tb/apcb_pin_model.sv */
// model of the switches and lamps on the four auxiliary pins
`timescale 1ns/1ns
module apcb_pin_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] sense,
    output logic [3:0] pin_in
);
    // a driven pin reads back its own level, an undriven one the sensor
    assign pin_in = (pin_out & ~pin_oe_n) | (sense & pin_oe_n);
endmodule

/* tb/apcb_top_asserts.sv */
// concurrent checks on the ports of the auxiliary pin control bank
`timescale 1ns/1ns
module apcb_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire apcb_pkg::apcb_ahb_req_t ahb_req,
    input wire apcb_pkg::apcb_ahb_rsp_t ahb_rsp,
    input wire logic usb_suspend,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n
);
    logic [7:0] sh_lo;
    logic [7:0] sh_hi;
    logic wr_pend;
    logic rd_pend;
    logic susp_q;
    logic [31:0] wr_addr;
    logic taken;
    logic [3:0] dirs;
    logic [3:0] lvls;
    assign taken = rstn && ahb_req.hsel && ahb_req.hready && ahb_req.htrans == apcb_pkg::HTRANS_NONSEQ;
    assign dirs = {sh_hi[4], sh_hi[0], sh_lo[4], sh_lo[0]};
    assign lvls = {sh_hi[7], sh_hi[3], sh_lo[7], sh_lo[3]};
    // shadow of the control registers; suspend entry reloads like reset
    always_ff @(posedge clock) begin
        wr_pend <= taken && ahb_req.hwrite;
        rd_pend <= taken && !ahb_req.hwrite;
        wr_addr <= ahb_req.haddr;
        susp_q <= usb_suspend;
        if (!rstn || (usb_suspend && !susp_q)) begin
            sh_lo <= apcb_pkg::RST_PINS_ONE_TWO;
            sh_hi <= apcb_pkg::RST_PINS_THREE_FOUR;
        end else if (wr_pend && wr_addr == 32'h164) begin
            sh_lo <= ahb_req.hwdata[7:0];
        end else if (wr_pend && wr_addr == 32'h168) begin
            sh_hi <= ahb_req.hwdata[7:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // pins change on the same edge as the control registers
    property p_pin(int i);
        pin_oe_n[i] == !dirs[i] && pin_out[i] == (dirs[i] & lvls[i]);
    endproperty
    a_pin_one_cfg: assert property (p_pin(0)) else $error("pin one config not applied");
    a_pin_two_cfg: assert property (p_pin(1)) else $error("pin two config not applied");
    a_pin_three_cfg: assert property (p_pin(2)) else $error("pin three config not applied");
    a_pin_four_cfg: assert property (p_pin(3)) else $error("pin four config not applied");
    a_out_level: assert property ((pin_out & ~pin_oe_n) == (lvls & dirs))
        else $error("driven level wrong");
    a_input_quiet: assert property ((pin_out & pin_oe_n) == 4'h0) else $error("input pin level leaks");
    a_suspend_dflt: assert property ($rose(usb_suspend) |-> ##2 pin_oe_n == 4'h7 && pin_out == 4'h8)
        else $error("suspend defaults missing");
    a_zero_wait: assert property (ahb_rsp.hreadyout && ahb_rsp.hresp == apcb_pkg::HRESP_OKAY)
        else $error("bus wait or error");
    a_read_idle: assert property (!rd_pend |-> ahb_rsp.hrdata == 32'h0) else $error("read data outside phase");
    a_reg_width: assert property (rd_pend |-> ahb_rsp.hrdata[31:8] == 24'h0) else $error("wide read data");
    c_suspend: cover property ($rose(usb_suspend));
    c_read_data: cover property (rd_pend && ahb_rsp.hrdata != 32'h0);
    c_pin_driven: cover property (pin_oe_n == 4'h0);
endmodule
bind apcb_top apcb_checker apcb_checker_inst (.clock(clock), .rstn(rstn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .usb_suspend(usb_suspend), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* tb/apcb_top_test.sv */
// self-checking testbench for the auxiliary pin control bank
`timescale 1ns/1ns
module apcb_top_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic usb_suspend = 1'b0;
    logic [3:0] sense = 4'h0;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic irq;
    apcb_pkg::apcb_ahb_req_t req = '0;
    apcb_pkg::apcb_ahb_req_t req_bus;
    apcb_pkg::apcb_ahb_rsp_t rsp;
    int error_cnt = 0;
    int comparisons = 0;
    logic [15:0] lfsr = 16'h002b;
    logic [31:0] rd;
    logic [7:0] c_lo;
    logic [7:0] c_hi;
    logic [3:0] t_old;
    logic [3:0] t_a;
    logic [3:0] exp_st;
    always #20 clock = ~clock;
    // the single slave's ready is the bus ready
    always_comb begin
        req_bus = req;
        req_bus.hready = rsp.hreadyout;
    end
    apcb_top apcb_top_inst (.clock(clock), .rstn(rstn), .ahb_req(req_bus), .ahb_rsp(rsp),
        .usb_suspend(usb_suspend), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
    apcb_pin_model apcb_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .sense(sense), .pin_in(pin_in));
    // ----
    // helpers
    // ----
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // bit k of every pin nibble, pin one in bit 0
    function automatic logic [3:0] fld(input int k);
        return {c_hi[4 + k], c_hi[k], c_lo[4 + k], c_lo[k]};
    endfunction
    function automatic logic [3:0] tru(input logic [3:0] v);
        return ~(v ^ fld(1));
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single transfer; waits on ready, no fixed latency assumed
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        req.hsel <= 1'b1;
        req.haddr <= a;
        req.htrans <= apcb_pkg::HTRANS_NONSEQ;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        do @(posedge clock); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        req.hwdata <= d;
        do @(posedge clock); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask
    task automatic chk_pins(input logic [3:0] oe_n, input logic [3:0] lvl);
        repeat (2) @(posedge clock);
        chk("pin_oe_n", {28'h0, oe_n}, {28'h0, pin_oe_n});
        chk("pin_out", {28'h0, lvl}, {28'h0, pin_out});
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog well above the roughly 800 cycles the run needs
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        chk_pins(4'h7, 4'h8);
        bus(1'b0, 32'h164, 32'h0);
        chk("ctrl_lo", {24'h0, apcb_pkg::RST_PINS_ONE_TWO}, rd);
        bus(1'b0, 32'h168, 32'h0);
        chk("ctrl_hi", 32'h90, rd);
        // random configs, then a read-clear and two sensor values each
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            {c_hi, c_lo} = lfsr;
            bus(1'b1, 32'h164, {lfsr, 8'h5a, c_lo});
            bus(1'b1, 32'h168, {8'h3c, lfsr, c_hi});
            chk_pins(~fld(0), fld(0) & fld(3));
            bus(1'b0, 32'h164, 32'h0);
            chk("ctrl_lo", {24'h0, c_lo}, rd);
            bus(1'b0, 32'h168, 32'h0);
            chk("ctrl_hi", {24'h0, c_hi}, rd);
            repeat (8) @(posedge clock);
            t_old = tru(sense);
            bus(1'b0, 32'h180, 32'h0);
            lfsr = next_rand(lfsr);
            sense <= lfsr[3:0];
            t_a = tru(lfsr[3:0]);
            repeat (8) @(posedge clock);
            sense <= lfsr[7:4];
            repeat (8) @(posedge clock);
            exp_st = ~fld(0) & ((fld(2) & (t_old | t_a)) | tru(lfsr[7:4]));
            bus(1'b0, 32'h180, 32'h0);
            chk("pin_status", {28'h0, exp_st}, rd);
        end
        // interrupt: mask, raise, unmask, clear
        c_lo = 8'h22;
        c_hi = 8'h22;
        bus(1'b1, 32'h164, 32'h22);
        bus(1'b1, 32'h168, 32'h22);
        sense <= 4'h0;
        repeat (8) @(posedge clock);
        bus(1'b1, 32'h184, 32'hf);
        bus(1'b1, 32'h188, 32'h0);
        sense <= 4'h5;
        repeat (8) @(posedge clock);
        bus(1'b0, 32'h184, 32'h0);
        chk("irq_status", 32'h5, rd);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, 32'h188, 32'h4);
        repeat (2) @(posedge clock);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, 32'h184, 32'h4);
        repeat (2) @(posedge clock);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b0, 32'h184, 32'h0);
        chk("irq_status", 32'h1, rd);
        bus(1'b0, 32'h188, 32'h0);
        chk("irq_mask", 32'h4, rd);
        bus(1'b1, 32'h3fc, 32'hffffffff);
        bus(1'b0, 32'h3fc, 32'h0);
        chk("unmapped", 32'h0, rd);
        // suspend entry, then a second reset, from an all-output setup
        bus(1'b1, 32'h164, 32'h11);
        bus(1'b1, 32'h168, 32'h11);
        chk_pins(4'h0, 4'h0);
        usb_suspend <= 1'b1;
        repeat (3) @(posedge clock);
        chk_pins(4'h7, 4'h8);
        bus(1'b0, 32'h168, 32'h0);
        chk("ctrl_hi", 32'h90, rd);
        usb_suspend <= 1'b0;
        bus(1'b1, 32'h164, 32'h11);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        chk_pins(4'h7, 4'h8);
        complete_run;
    end
endmodule
